// ==== src/nsc_defs.vh ====
/*
 * nsc_defs.vh: opcodes, register addresses, field positions and reset values
 * for the serial-nand status, configuration and extended ecc register block.
 * Assumes it is included by the design files of the block only.
 */
`ifndef NSC_DEFS_VH
`define NSC_DEFS_VH

// instruction opcodes
`define NSC_CMD_WREN      8'h06
`define NSC_CMD_WRDI      8'h04
`define NSC_CMD_RESET     8'hff
`define NSC_CMD_RDSR      8'h0f
`define NSC_CMD_WRSR      8'h1f
`define NSC_CMD_EXT_RD    8'h7a
`define NSC_CMD_EXT_WR    8'h7b
`define NSC_CMD_PAGE_RD   8'h13
`define NSC_CMD_PROG_EXE  8'h10
`define NSC_CMD_ERASE     8'hd8
`define NSC_CMD_READ      8'h03
`define NSC_CMD_READ_ID   8'h9f

// register addresses
`define NSC_ADDR_CFG      8'hb0
`define NSC_ADDR_STAT     8'hc0
`define NSC_ADDR_THRESH   8'h10
`define NSC_ADDR_FLAGS    8'h20
`define NSC_ADDR_MAXFLIP  8'h30
`define NSC_ADDR_CNT_LO   8'h40
`define NSC_ADDR_CNT_HI   8'h50

// configuration register fields
`define NSC_CFG_ECC_EN    4
`define NSC_CFG_BUF_MODE  3
`define NSC_CFG_HOLD_OFF  0

// status register fields
`define NSC_ST_OUT_HI     5
`define NSC_ST_OUT_LO     4
`define NSC_ST_PFAIL      3
`define NSC_ST_EFAIL      2
`define NSC_ST_WEL        1
`define NSC_ST_BUSY       0

// reset values
`define NSC_RST_ECC_EN    1'b1
`define NSC_RST_BUF_MODE  1'b1
`define NSC_RST_HOLD_OFF  1'b0
`define NSC_RST_THRESH    4'h4

// threshold codes and flip-count encodings
`define NSC_THR_RESERVED  4'h0
`define NSC_THR_MAX_CNT   4'h8
`define NSC_FLIP_UNCORR   4'hf

// correction outcome encodings
`define NSC_OUT_CLEAN     2'b00
`define NSC_OUT_FIXED     2'b01
`define NSC_OUT_UNCORR    2'b10
`define NSC_OUT_OVER      2'b11

// array operations
`define NSC_OP_LOAD       2'd0
`define NSC_OP_PROG       2'd1
`define NSC_OP_ERASE      2'd2

// data buffer size: 2048 main plus 128 spare bytes
`define NSC_BUF_BYTES     2176

`endif

// ==== src/nsc_regs.v ====
/*
 * nsc_regs.v: spi-side command decoder with the configuration, status and
 * extended ecc feature registers of a serial nand device.
 * Assumes spi mode 0 pins no faster than clk/8, a data buffer that answers
 * buf_addr on the next clk, and an array engine that pulses array_done.
 */
// How it works
// - hold_off_bit set makes the hold pin have no effect at all.
// - buffer_mode_select 1 is buffer read; 0 with correction off is sequential read.
// - after reset the device loads page 0 into the buffer while busy.
// - buffer read starts at given column, goes high impedance after byte 2175.
// - sequential read starts at byte 0 and rolls into the next page.
// - sequential read treats the column bytes as dummy.
// - buffer_mode_select 0 disables correction regardless of correction_enable.
// - correction_outcome reports clean, fixed, uncorrectable or fixed-over-threshold.
// - correction_outcome clears on reset, reset command and page data read.
// - program_fault sets on timeout or locked target, clears on good start or reset.
// - erase_fault sets on timeout or locked target, clears on good start or reset.
// - write_permit_latch set by write enable, cleared by disable, program, erase, load.
// - busy during power-up and operations; only status and id reads accepted.
// - busy clears when the internal operation finishes.
// - flip_threshold is written at 10h bits 7:4, codes 1-8 or f only.
// - flip_threshold resets to 4.
// - sector_over_threshold flags set where sector count reaches the threshold.
// - correction_enable resets to 1 and survives the reset command.
`include "nsc_defs.vh"
module nsc_regs #(
   parameter        BUF_BYTES = `NSC_BUF_BYTES,
   parameter [23:0] DEVICE_ID = 24'h5a_a5_3c   // arbitrary value
)
(
   input  wire        clk,
   input  wire        reset,
   input  wire        ce,
   input  wire        sclk,
   input  wire        cs_n,
   input  wire        mosi,
   input  wire        hold_n,
   output reg         miso,
   output reg         miso_oe_n,
   output reg         array_start,
   output reg  [1:0]  array_op,
   output reg  [15:0] array_page,
   output reg         seq_next_page,
   output reg         ecc_active,
   output reg  [11:0] buf_addr,
   input  wire [7:0]  buf_data,
   input  wire        array_done,
   input  wire        array_timeout,
   input  wire        target_locked,
   input  wire [15:0] flip_count
);

   localparam [3:0]  ST_OP  = 4'b0001;
   localparam [3:0]  ST_ARG = 4'b0010;
   localparam [3:0]  ST_OUT = 4'b0100;
   localparam [3:0]  ST_SKIP = 4'b1000;
   localparam [31:0] BUF_LAST = BUF_BYTES - 1;
   localparam [31:0] BUF_SIZE = BUF_BYTES;
   localparam [11:0] LAST_COL = BUF_LAST[11:0];   // column counter is 12 bits wide
   localparam [15:0] END_COL  = BUF_SIZE[15:0];

   wire       s_sclk;
   wire       s_cs_n;
   wire       s_mosi;
   wire       s_hold_n;
   reg        sclk_q;
   reg  [3:0] state;
   reg  [7:0] cmd;
   reg  [7:0] rx;
   reg  [2:0] rx_bit;
   reg  [1:0] arg_cnt;
   reg  [7:0] arg0;
   reg  [7:0] arg1;
   reg  [7:0] rd_addr;
   reg  [7:0] tx;
   reg  [2:0] tx_bit;
   reg  [1:0] id_idx;
   reg        driving;
   reg        buf_end;
   reg        busy;
   reg  [1:0] running_op;
   reg        powerup_pend;
   reg        write_permit_latch;
   reg        program_fault;
   reg        erase_fault;
   reg  [1:0] correction_outcome;
   reg        correction_enable;
   reg        buffer_mode_select;
   reg        hold_off_bit;
   reg  [3:0] flip_threshold;
   reg  [3:0] sector_over_threshold;
   reg  [15:0] flips;
   reg  [3:0] max_cnt;
   reg  [2:0] max_sec;
   wire       rise;
   wire       fall;
   wire       hold_act;
   wire [7:0] rx_byte;
   wire [15:0] col_arg;
   reg  [7:0] reg_value;
   reg  [7:0] next_byte;
   reg  [1:0] arg_last;
   reg        any_unc;
   reg  [3:0] mx;
   reg  [2:0] ms;
   reg  [3:0] fl;
   reg  [3:0] c;
   reg  [1:0] next_outcome;
   integer    i;

   nsc_sync #(.W(4), .RESET_VAL(4'b0101)) u_sync (
      .clk   (clk),
      .reset (reset),
      .ce    (ce),
      .d     ({sclk, cs_n, mosi, hold_n}),
      .q     ({s_sclk, s_cs_n, s_mosi, s_hold_n})
   );

   // edges of the sampled spi clock, frozen while hold is honoured
   assign hold_act = ~s_hold_n & ~hold_off_bit;
   assign rise     = s_sclk & ~sclk_q & ~s_cs_n & ~hold_act;
   assign fall     = ~s_sclk & sclk_q & ~s_cs_n & ~hold_act;
   assign rx_byte  = {rx[6:0], s_mosi};
   assign col_arg  = {arg0, arg1};

   // register read mux; reserved bits return zero
   always @*
   begin
      reg_value = 8'h00;
      case (rd_addr)
         `NSC_ADDR_CFG:
         begin
            reg_value[`NSC_CFG_ECC_EN]   = correction_enable;
            reg_value[`NSC_CFG_BUF_MODE] = buffer_mode_select;
            reg_value[`NSC_CFG_HOLD_OFF] = hold_off_bit;
         end
         `NSC_ADDR_STAT:
         begin
            reg_value[`NSC_ST_OUT_HI:`NSC_ST_OUT_LO] = correction_outcome;
            reg_value[`NSC_ST_PFAIL] = program_fault;
            reg_value[`NSC_ST_EFAIL] = erase_fault;
            reg_value[`NSC_ST_WEL]   = write_permit_latch;
            reg_value[`NSC_ST_BUSY]  = busy;
         end
         `NSC_ADDR_THRESH:  reg_value = {flip_threshold, 4'h0};
         `NSC_ADDR_FLAGS:   reg_value = {4'h0, sector_over_threshold};
         `NSC_ADDR_MAXFLIP: reg_value = {max_cnt, 1'b0, max_sec};
         `NSC_ADDR_CNT_LO:  reg_value = flips[7:0];
         `NSC_ADDR_CNT_HI:  reg_value = flips[15:8];
         default:           reg_value = 8'h00;
      endcase
   end

   // next byte to shift out, by command
   always @*
   begin
      next_byte = reg_value;
      if (cmd == `NSC_CMD_READ)
         next_byte = buf_data;
      else if (cmd == `NSC_CMD_READ_ID)
      begin
         case (id_idx)
            2'd0:    next_byte = DEVICE_ID[23:16];
            2'd1:    next_byte = DEVICE_ID[15:8];
            default: next_byte = DEVICE_ID[7:0];
         endcase
      end
   end

   // index of the last argument byte per opcode, two for all other opcodes
   always @*
   begin
      case (cmd)
         `NSC_CMD_RDSR, `NSC_CMD_EXT_RD, `NSC_CMD_READ_ID: arg_last = 2'd0;
         `NSC_CMD_WRSR, `NSC_CMD_EXT_WR:                   arg_last = 2'd1;
         default:                                          arg_last = 2'd2;
      endcase
   end

   // per-sector flip evaluation against the threshold
   always @*
   begin
      any_unc = 1'b0;
      mx      = 4'h0;
      ms      = 3'd0;
      fl      = 4'h0;
      c       = 4'h0;
      for (i = 0; i < 4; i = i + 1)
      begin
         c = flip_count[4*i +: 4];
         if (c == `NSC_FLIP_UNCORR)
            any_unc = 1'b1;
         if (c > mx)                                        // strict keeps lowest sector
         begin
            mx = c;
            ms = i[2:0];
         end
         if (flip_threshold == `NSC_FLIP_UNCORR ? c == `NSC_FLIP_UNCORR : c >= flip_threshold)
            fl[i] = 1'b1;
      end
      if (any_unc)
         next_outcome = `NSC_OUT_UNCORR;
      else if (mx == 4'h0)
         next_outcome = `NSC_OUT_CLEAN;
      else if (flip_threshold != `NSC_FLIP_UNCORR && mx > flip_threshold)
         next_outcome = `NSC_OUT_OVER;
      else
         next_outcome = `NSC_OUT_FIXED;
   end

   // command engine, registers and output shifter
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sclk_q                <= 1'b0;
         state                 <= ST_OP;
         cmd                   <= 8'h00;
         rx                    <= 8'h00;
         rx_bit                <= 3'd0;
         arg_cnt               <= 2'd0;
         arg0                  <= 8'h00;
         arg1                  <= 8'h00;
         rd_addr               <= 8'h00;
         tx                    <= 8'h00;
         tx_bit                <= 3'd0;
         id_idx                <= 2'd0;
         driving               <= 1'b0;
         buf_end               <= 1'b0;
         busy                  <= 1'b1;
         running_op            <= `NSC_OP_LOAD;
         powerup_pend          <= 1'b1;
         write_permit_latch    <= 1'b0;
         program_fault         <= 1'b0;
         erase_fault           <= 1'b0;
         correction_outcome    <= `NSC_OUT_CLEAN;
         correction_enable     <= `NSC_RST_ECC_EN;
         buffer_mode_select    <= `NSC_RST_BUF_MODE;
         hold_off_bit          <= `NSC_RST_HOLD_OFF;
         flip_threshold        <= `NSC_RST_THRESH;
         sector_over_threshold <= 4'h0;
         flips                 <= 16'h0000;
         max_cnt               <= 4'h0;
         max_sec               <= 3'd0;
         miso                  <= 1'b0;
         miso_oe_n             <= 1'b1;
         array_start           <= 1'b0;
         array_op              <= `NSC_OP_LOAD;
         array_page            <= 16'h0000;
         seq_next_page         <= 1'b0;
         ecc_active            <= 1'b0;
         buf_addr              <= 12'h000;
      end
      else if (ce)
      begin
         sclk_q        <= s_sclk;
         array_start   <= 1'b0;
         seq_next_page <= 1'b0;
         ecc_active    <= correction_enable & buffer_mode_select;
         miso_oe_n     <= ~(driving & ~hold_act & ~s_cs_n);
         // power-up load of page 0
         if (powerup_pend)
         begin
            powerup_pend <= 1'b0;
            array_start  <= 1'b1;
            array_op     <= `NSC_OP_LOAD;
            array_page   <= 16'h0000;
            running_op   <= `NSC_OP_LOAD;
         end
         // frame ends when chip select is high
         if (s_cs_n)
         begin
            state   <= ST_OP;
            rx_bit  <= 3'd0;
            driving <= 1'b0;
         end
         else if (rise)
         begin
            rx     <= rx_byte;
            rx_bit <= rx_bit + 3'd1;
            if (rx_bit == 3'd7)
            begin
               case (state)
                  ST_OP:
                  begin
                     cmd     <= rx_byte;
                     arg_cnt <= 2'd0;
                     state   <= ST_SKIP;
                     if (busy && rx_byte != `NSC_CMD_RDSR && rx_byte != `NSC_CMD_READ_ID)
                        state <= ST_SKIP;
                     else
                     begin
                        case (rx_byte)
                           `NSC_CMD_WREN: write_permit_latch <= 1'b1;
                           `NSC_CMD_WRDI: write_permit_latch <= 1'b0;
                           `NSC_CMD_RESET:
                           begin
                              correction_outcome <= `NSC_OUT_CLEAN;
                              program_fault      <= 1'b0;
                              erase_fault        <= 1'b0;
                           end
                           `NSC_CMD_RDSR, `NSC_CMD_WRSR, `NSC_CMD_EXT_RD, `NSC_CMD_EXT_WR,
                           `NSC_CMD_PAGE_RD, `NSC_CMD_PROG_EXE, `NSC_CMD_ERASE,
                           `NSC_CMD_READ, `NSC_CMD_READ_ID: state <= ST_ARG;
                           default: state <= ST_SKIP;
                        endcase
                     end
                  end
                  ST_ARG:
                  begin
                     arg_cnt <= arg_cnt + 2'd1;
                     if (arg_cnt == 2'd0)
                        arg0 <= rx_byte;
                     if (arg_cnt == 2'd1)
                        arg1 <= rx_byte;
                     if (arg_cnt == arg_last)
                     begin
                        state  <= ST_SKIP;
                        tx_bit <= 3'd0;
                        id_idx <= 2'd0;
                        case (cmd)
                           `NSC_CMD_RDSR, `NSC_CMD_EXT_RD:
                           begin
                              rd_addr <= rx_byte;
                              state   <= ST_OUT;
                           end
                           `NSC_CMD_READ_ID: state <= ST_OUT;
                           `NSC_CMD_WRSR:
                              if (arg0 == `NSC_ADDR_CFG)
                              begin
                                 correction_enable  <= rx_byte[`NSC_CFG_ECC_EN];
                                 buffer_mode_select <= rx_byte[`NSC_CFG_BUF_MODE];
                                 hold_off_bit       <= rx_byte[`NSC_CFG_HOLD_OFF];
                              end
                           `NSC_CMD_EXT_WR:
                              if (arg0 == `NSC_ADDR_THRESH &&
                                  ((rx_byte[7:4] != `NSC_THR_RESERVED && rx_byte[7:4] <= `NSC_THR_MAX_CNT) ||
                                   rx_byte[7:4] == `NSC_FLIP_UNCORR))
                                 flip_threshold <= rx_byte[7:4];
                           `NSC_CMD_PAGE_RD:
                           begin
                              correction_outcome <= `NSC_OUT_CLEAN;
                              write_permit_latch <= 1'b0;
                              busy               <= 1'b1;
                              running_op         <= `NSC_OP_LOAD;
                              array_op           <= `NSC_OP_LOAD;
                              array_page         <= {arg1, rx_byte};
                              array_start        <= 1'b1;
                           end
                           `NSC_CMD_PROG_EXE, `NSC_CMD_ERASE:
                              if (write_permit_latch)
                              begin
                                 write_permit_latch <= 1'b0;
                                 if (target_locked)
                                 begin
                                    if (cmd == `NSC_CMD_ERASE)
                                       erase_fault <= 1'b1;
                                    else
                                       program_fault <= 1'b1;
                                 end
                                 else
                                 begin
                                    if (cmd == `NSC_CMD_ERASE)
                                       erase_fault <= 1'b0;
                                    else
                                       program_fault <= 1'b0;
                                    busy        <= 1'b1;
                                    running_op  <= (cmd == `NSC_CMD_ERASE) ? `NSC_OP_ERASE : `NSC_OP_PROG;
                                    array_op    <= (cmd == `NSC_CMD_ERASE) ? `NSC_OP_ERASE : `NSC_OP_PROG;
                                    array_page  <= {arg1, rx_byte};
                                    array_start <= 1'b1;
                                 end
                              end
                           `NSC_CMD_READ:
                           begin
                              state <= ST_OUT;
                              if (buffer_mode_select)
                              begin
                                 buf_addr <= col_arg[11:0];
                                 buf_end  <= (col_arg >= END_COL);
                              end
                              else
                              begin
                                 buf_addr <= 12'h000;
                                 buf_end  <= 1'b0;
                              end
                           end
                           default: state <= ST_SKIP;
                        endcase
                     end
                  end
                  default: state <= state;
               endcase
            end
         end
         // output shifter, one bit per falling edge
         if (!s_cs_n && fall && state == ST_OUT)
         begin
            tx_bit <= tx_bit + 3'd1;
            if (tx_bit == 3'd0)
            begin
               miso    <= next_byte[7];
               tx      <= {next_byte[6:0], 1'b0};
               driving <= ~(cmd == `NSC_CMD_READ && buf_end);
               id_idx  <= (id_idx == 2'd2) ? 2'd0 : id_idx + 2'd1;
               if (cmd == `NSC_CMD_READ && !buf_end)
               begin
                  if (buf_addr != LAST_COL)
                     buf_addr <= buf_addr + 12'h001;
                  else if (buffer_mode_select)
                     buf_end <= 1'b1;
                  else
                  begin
                     buf_addr      <= 12'h000;
                     seq_next_page <= 1'b1;
                  end
               end
            end
            else
            begin
               miso <= tx[7];
               tx   <= {tx[6:0], 1'b0};
            end
         end
         // completion of the internal operation
         if (array_done && busy && !powerup_pend)
         begin
            busy <= 1'b0;
            if (running_op == `NSC_OP_LOAD && ecc_active)
            begin
               correction_outcome    <= next_outcome;
               sector_over_threshold <= fl;
               flips                 <= flip_count;
               max_cnt               <= mx;
               max_sec               <= ms;
            end
            if (running_op == `NSC_OP_PROG && array_timeout)
               program_fault <= 1'b1;
            if (running_op == `NSC_OP_ERASE && array_timeout)
               erase_fault <= 1'b1;
         end
      end
   end

endmodule // nsc_regs

// ==== src/nsc_sync.v ====
/*
 * nsc_sync.v: two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk; only the second stage is used.
 */
module nsc_sync #(
   parameter         W         = 1,
   parameter [W-1:0] RESET_VAL = {W{1'b0}}
)
(
   input  wire         clk,
   input  wire         reset,
   input  wire         ce,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);

   reg [W-1:0] meta;

   // two stages, the first read only by the second
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         meta <= RESET_VAL;
         q    <= RESET_VAL;
      end
      else if (ce)
      begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule // nsc_sync

// ==== tb/nsc_host_model.sv ====
/* nsc_host_model.sv: spi mode 0 host, 200 ns sclk, one frame per call.
   assumes a 40 mhz clk to pace the link. */
module nsc_host_model (
   input  wire logic clk,
   input  wire logic miso,
   input  wire logic miso_oe_n,
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      sclk = 0;
      cs_n = 1;
      mosi = 0;
   end
   // nb bits out msb first, then nr bytes in; sclk stands still between frames
   task automatic xfer(input logic [31:0] t, input int nb, input int nr,
                       output logic [23:0] rx, output logic oe);
      int i;
      rx = 0;
      cs_n = 0;
      for (i = 0; i < nb + 8 * nr; i++)
      begin
         mosi = (i < nb) ? t[nb - 1 - i] : ~mosi;
         repeat (4) @(negedge clk);
         sclk = 1;
         repeat (4) @(negedge clk);
         if (i >= nb) rx = {rx[22:0], miso_oe_n ? ~miso : miso}; // released line reads inverted
         oe = miso_oe_n;
         sclk = 0;
      end
      mosi = ~mosi; // released line
      repeat (8) @(negedge clk);
      cs_n = 1;
      repeat (8) @(negedge clk);
   endtask
endmodule // nsc_host_model

// ==== tb/nsc_regs_monitor.sv ====
/* nsc_regs_monitor.sv: port assertions for nsc_regs.
   assumes ce high and spi half periods of 4 clk or more. */
module nsc_regs_monitor (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        sclk,
   input wire logic        cs_n,
   input wire logic        miso,
   input wire logic        miso_oe_n,
   input wire logic        array_start,
   input wire logic [1:0]  array_op,
   input wire logic [15:0] array_page,
   input wire logic        seq_next_page,
   input wire logic        ecc_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // strobes last one cycle
   a_start_pulse: assert property (array_start |=> !array_start) else $error("start too long");
   a_wrap_pulse: assert property (seq_next_page |=> !seq_next_page) else $error("wrap too long");
   // power-up load of page 0, correction on
   a_boot_load: assert property ($fell(reset) |-> ##[0:2]
      (array_start && array_op == 2'd0 && array_page == 16'h0)) else $error("no boot load");
   a_ecc_boot: assert property ($fell(reset) |-> ##[1:3] ecc_active) else $error("ecc off at boot");
   a_op_legal: assert property (array_start |-> array_op != 2'd3) else $error("bad op");
   a_seq_no_ecc: assert property (seq_next_page |-> !ecc_active) else $error("ecc in seq read");
   // output released when deselected, shifted while sclk low
   a_idle_hiz: assert property (cs_n [*6] |-> miso_oe_n) else $error("drives when idle");
   a_shift_edge: assert property (!miso_oe_n && $changed(miso) |-> !sclk) else $error("late shift");
   c_wrap: cover property (seq_next_page);
   c_prog: cover property (array_start && array_op == 2'd1);
   c_erase: cover property (array_start && array_op == 2'd2);
endmodule // nsc_regs_monitor
bind nsc_regs nsc_regs_monitor nsc_regs_monitor_inst (.clk(clk), .reset(reset), .sclk(sclk),
   .cs_n(cs_n), .miso(miso), .miso_oe_n(miso_oe_n), .array_start(array_start), .array_op(array_op),
   .array_page(array_page), .seq_next_page(seq_next_page), .ecc_active(ecc_active));

// ==== tb/test_nsc_regs.sv ====
/* test_nsc_regs.sv: bench for nsc_regs with host model, buffer and array engine.
   assumes a 16-byte buffer via BUF_BYTES. */
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_nsc_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, reset = 1, ad = 0, tmo = 0, lock = 0, oe, hn = 1;
   logic [7:0]  bd = 0;
   logic [15:0] fc = 0;
   logic [23:0] rx;
   wire         sclk, cs_n, mosi, miso, oe_n, st, snp, ea;
   wire  [1:0]  op;
   wire  [15:0] pg;
   wire  [11:0] ba;
   int          error_cnt = 0, checks_done = 0, i, k, wraps = 0;
   // frame, bit count, expected byte; 16-bit frames are reads
   logic [47:0] rows [14] = '{{32'h0fb0, 8'd16, 8'h18}, {32'h7a10, 8'd16, 8'h40}, {32'h06, 8'd8, 8'h0},
      {32'h0fc0, 8'd16, 8'h02}, {32'h04, 8'd8, 8'h0}, {32'h0fc0, 8'd16, 8'h00}, {32'h7b1080, 8'd24, 8'h0},
      {32'h7a10, 8'd16, 8'h80}, {32'h7b1000, 8'd24, 8'h0}, {32'h7a10, 8'd16, 8'h80},
      {32'h7b102f, 8'd24, 8'h0}, {32'h7a10, 8'd16, 8'h20}, {32'h7a77, 8'd16, 8'h0}, {32'h7a40, 8'd16, 8'h0}};
   nsc_regs #(.BUF_BYTES(16)) nsc_regs_inst (.clk(clk), .reset(reset), .ce(1'b1), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi), .hold_n(hn), .miso(miso), .miso_oe_n(oe_n), .array_start(st),
      .array_op(op), .array_page(pg), .seq_next_page(snp), .ecc_active(ea), .buf_addr(ba),
      .buf_data(bd), .array_done(ad), .array_timeout(tmo), .target_locked(lock), .flip_count(fc));
   nsc_host_model nsc_host_model_inst (.clk(clk), .miso(miso), .miso_oe_n(oe_n), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi));
   initial forever #12.5 clk = ~clk;
   // buffer answers next clk; array op done 400 clk after start
   always @(posedge clk) bd <= ba[7:0] ^ 8'h5a;
   always @(posedge clk) if (snp) wraps++;
   initial forever
   begin
      @(posedge clk iff st);
      repeat (400) @(negedge clk);
      ad = 1;
      @(negedge clk);
      ad = 0;
   end
   task x(input logic [31:0] t, input int nb, input int nr = 0);
      nsc_host_model_inst.xfer(t, nb, nr, rx, oe);
   endtask
   task wait_done;
      for (i = 0; !ad && i < 2000; i++) @(posedge clk);
      if (!ad) begin error_cnt++; finish_test; end
      repeat (4) @(negedge clk);
   endtask
   task finish_test;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(negedge clk);
      reset = 0;
      x(32'h0fc0, 16, 1);
      `CHK("busy", 8'h01, rx[7:0])
      x(32'h06, 8);
      i = 0; wait_done;
      x(32'h0fc0, 16, 1);
      `CHK("ready", 8'h00, rx[7:0])
      for (i = 0; i < 14; i++)
         if (rows[i][15:8] == 16) begin x(rows[i][47:16], 16, 1); `CHK("row", rows[i][7:0], rx[7:0]) end
         else x(rows[i][47:16], rows[i][15:8]);
      $display("table done");
      fc = 16'h3021;
      x(32'h06, 8);
      x(32'h13000005, 32);
      i = 0; wait_done;
      `CHK("page", 18'h00005, {op, pg})
      x(32'h0fc0, 16, 1);
      `CHK("outcome", 8'h30, rx[7:0])
      x(32'h7a20, 16, 1);
      `CHK("flags", 8'h0a, rx[7:0])
      x(32'hff, 8);
      x(32'h0fc0, 16, 1);
      `CHK("cleared", 8'h00, rx[7:0])
      x(32'h0fb0, 16, 1);
      `CHK("cfg kept", 8'h18, rx[7:0])
      for (k = 0; k < 2; k++)
      begin
         lock = 1;
         x(32'h06, 8);
         x({k ? 8'hd8 : 8'h10, 24'h7}, 32);
         lock = 0;
         repeat (450) @(negedge clk);
         x(32'h0fc0, 16, 1);
         `CHK("locked", k ? 8'h04 : 8'h08, rx[7:0] & 8'h0c)
         tmo = 1;
         x(32'h06, 8);
         x({k ? 8'hd8 : 8'h10, 24'h7}, 32);
         x(32'h0fc0, 16, 1);
         `CHK("started", 8'h00, rx[7:0] & 8'h0c)
         i = 0; wait_done;
         tmo = 0;
         x(32'h0fc0, 16, 1);
         `CHK("timeout", k ? 8'h04 : 8'h08, rx[7:0] & 8'h0c)
         x(32'hff, 8);
         x(32'h0fc0, 16, 1);
         `CHK("reset cmd", 8'h00, rx[7:0] & 8'h0c)
      end
      $display("faults done");
      hn = 0;
      x(32'h06, 8);
      hn = 1;
      x(32'h0fc0, 16, 1);
      `CHK("held", 8'h00, rx[7:0])
      x(32'h1fb019, 24);
      hn = 0;
      x(32'h06, 8);
      x(32'h0fc0, 16, 1);
      `CHK("hold off", 8'h02, rx[7:0])
      hn = 1;
      x(32'h03000edd, 32, 3);
      `CHK("buf data", 16'h5455, rx[23:8])
      `CHK("buf end", 1'b1, oe)
      x(32'h1fb010, 24);
      `CHK("ecc off", 1'b0, ea)
      x(32'h1fb000, 24);
      x(32'h03000edd, 32, 17);
      `CHK("seq wrap", 24'h54555a, rx)
      `CHK("wraps", 1, wraps)
      $display("reads done");
      finish_test;
   end
endmodule // test_nsc_regs
